// ---- hdl/drive_misc_pkg.sv ----
// Constants for the drive miscellaneous configuration block
package drive_misc_pkg;
   // ----------------------------------------
   // Parameter indices (menu*100 + param)
   // ----------------------------------------
   localparam logic [10:0] IDX_MENU_SLOT0 = 11'h44D;
   localparam logic [10:0] IDX_NODE_ADDR = 11'h457;
   localparam logic [10:0] IDX_RATE_SEL = 11'h458;
   localparam logic [10:0] IDX_MODE_SEL = 11'h459;
   localparam logic [10:0] IDX_RSVD = 11'h45A;
   localparam logic [10:0] IDX_MAIN_REV = 11'h45B;
   localparam logic [10:0] IDX_OPT_REV = 11'h45C;
   localparam logic [10:0] IDX_LOCK_CODE = 11'h45D;
   localparam logic [10:0] IDX_BOOT_DISP = 11'h45E;
   localparam logic [10:0] IDX_XFER_SEL = 11'h45F;
   localparam logic [10:0] IDX_SCALE = 11'h460;
   localparam logic [10:0] IDX_STATUS = 11'h461;
   localparam logic [10:0] IDX_LED_OVR = 11'h462;
   localparam logic [10:0] IDX_HV_BOARD = 11'h463;
   localparam logic [10:0] IDX_RIDE_EN = 11'h464;
   localparam int MENU_SLOTS = 10;
   // ----------------------------------------
   // Limits, reset values, codes
   // ----------------------------------------
   localparam logic [6:0] ADDR_MAX = 7'h63;
   localparam logic [6:0] ADDR_RST = 7'h01;
   localparam logic [2:0] MODE_ASCII = 3'h1;
   localparam logic [2:0] MODE_VAR_OUT = 3'h2;
   localparam logic [2:0] MODE_VAR_IN = 3'h3;
   localparam logic [2:0] MODE_WIDE = 3'h4;
   localparam logic [10:0] SCALE_RST = 11'h3E8;
   localparam logic [10:0] PARAM_MAX = 11'h7CF;
   localparam logic [7:0] CODE_OPEN = 8'h00;
   localparam logic [7:0] CODE_FACTORY = 8'h95;
   localparam logic [15:0] STORE_CMD = 16'h0001;
   localparam logic [9:0] MAIN_REV_ID = 10'h07B; // Arbitrary value
   localparam logic [9:0] OPT_REV_ID = 10'h000; // Arbitrary value
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_LO = 4800;
   localparam int BAUD_HI = 9600;
   localparam int BIT_LO_CYC = CLK_HZ / BAUD_LO;
   localparam int BIT_HI_CYC = CLK_HZ / BAUD_HI;
   localparam int HEALTHY_MS = 40;
   localparam int HEALTHY_CYC = HEALTHY_MS * (CLK_HZ / 1000);
   localparam int RESTART_MS = 340;
   localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
   localparam int WIDE_DIGITS = 5;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
endpackage : drive_misc_pkg

// ---- hdl/baud_tick.sv ----
// Serial bit-rate enable divider
`timescale 1ns/1ps
module baud_tick
   import drive_misc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic fast,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } state_t;
   state_t st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == 16'(fast ? BIT_HI_CYC - 1 : BIT_LO_CYC - 1)) begin
         st_nxt.cnt = 16'h0000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign tick = st_r.tick;
endmodule : baud_tick

// ---- hdl/wide_ascii.sv ----
// Wide integer to five unsigned ASCII digits
`timescale 1ns/1ps
module wide_ascii
   import drive_misc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Value in
   input wire logic start,
   input wire logic [15:0] value,
   // Digits out, most significant first
   output logic [39:0] digits,
   output logic done
);
   typedef struct packed {
      logic [15:0] rem;
      logic [2:0] pos;
      logic busy;
      logic [39:0] dig;
      logic done;
   } state_t;
   state_t st_r, st_nxt;
   logic [15:0] pw;
   always_comb begin
      case (st_r.pos)
         3'h0: pw = 16'h2710;
         3'h1: pw = 16'h03E8;
         3'h2: pw = 16'h0064;
         3'h3: pw = 16'h000A;
         default: pw = 16'h0001;
      endcase
   end
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (start && !st_r.busy) begin
         st_nxt.rem = value;
         st_nxt.pos = 3'h0;
         st_nxt.busy = 1'b1;
         st_nxt.dig = {WIDE_DIGITS{ASCII_ZERO}};
      end else if (st_r.busy) begin
         if (st_r.rem >= pw) begin
            st_nxt.rem = st_r.rem - pw;
            st_nxt.dig[8'(39 - 8 * st_r.pos) -: 8] = st_r.dig[8'(39 - 8 * st_r.pos) -: 8] + 8'h01;
         end else if (st_r.pos == 3'(WIDE_DIGITS - 1)) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.pos = st_r.pos + 3'h1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign digits = st_r.dig;
   assign done = st_r.done;
endmodule : wide_ascii

// ---- hdl/drive_misc_config.sv ----
// Miscellaneous configuration, serial setup and dip ride-through
// Behaviour
// - Node address 0..99, 100 reads 99
// - Rate bit: 0 is 4800, 1 is 9600
// - Rate change waits for drive reset
// - Port mode 1..4, default ASCII
// - Mode 2 sends, mode 3 writes selected
// - Mode 3 scales input by factor
// - Mode 4 sends outgoing, stores incoming
// - Wide integer read out as five digits on request
// - Mode 4 sends one item per mains cycle
// - Lock code gates write access
// - Store when param zero is one, reset
// - Status byte bit packing fixed
// - LED override shows writable status byte
// - Ride-through repurposes second analogue input
// - Low mains inhibits firing, blanks display
// - Healthy 40 ms, reset, rerun if commanded
// - Restart completes within about 340 ms
// - Menu slots select parameter by index
// - Power-on display from boot selector
`timescale 1ns/1ps
module drive_misc_config
   import drive_misc_pkg::*;
#(
   parameter int HEALTHY_CYCLES = HEALTHY_CYC,
   parameter int RESTART_CYCLES = RESTART_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Parameter access port
   input wire logic par_wr,
   input wire logic [10:0] par_idx,
   input wire logic [15:0] par_wdata,
   output logic [15:0] par_rdata,
   output logic par_denied,
   // Drive reset and parameter zero
   input wire logic drive_reset_cmd,
   input wire logic [15:0] param_zero,
   output logic store_pulse,
   // Serial data path
   input wire logic rx_valid,
   input wire logic [15:0] rx_value,
   input wire logic [15:0] src_value,
   input wire logic [15:0] wide_out_value,
   output logic tx_valid,
   output logic [15:0] tx_value,
   output logic dst_wr,
   output logic [10:0] dst_idx,
   output logic [15:0] dst_value,
   output logic [15:0] wide_in_value,
   output logic [39:0] wide_digits,
   output logic wide_digits_valid,
   input wire logic wide_read_req,
   output logic rate_fast_active,
   output logic bit_tick,
   input wire logic mains_cycle,
   // Drive state and keypad
   input wire logic [7:0] drive_flags,
   output logic [6:0] keypad_leds,
   output logic [10:0] display_param,
   output logic display_blank,
   output logic [10:0] menu_slot_idx [MENU_SLOTS],
   output logic hv_board,
   // Ride-through
   input wire logic mains_sense_input,
   input wire logic run_cmd,
   input wire logic enable_cmd,
   output logic analog2_is_sense,
   output logic fire_inhibit,
   output logic self_reset,
   output logic run_resume
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [2:0] {
      RT_RUN = 3'b001,
      RT_DIP = 3'b010,
      RT_RST = 3'b100
   } rt_state_t;
   typedef struct packed {
      logic [6:0] node_addr;
      logic rate_sel;
      logic rate_act;
      logic [2:0] mode;
      logic [7:0] rsvd;
      logic [7:0] lock_code;
      logic [7:0] lock_stored;
      logic unlocked;
      logic [10:0] boot_disp;
      logic [10:0] xfer_sel;
      logic [10:0] scale;
      logic [7:0] status_w;
      logic led_ovr;
      logic hv;
      logic ride_en;
      logic [10:0] disp;
      logic boot_done;
      logic tx_v;
      logic [15:0] tx_d;
      logic dst_v;
      logic [15:0] dst_d;
      logic [15:0] wide_in;
      logic store;
      logic [2:0] sense_sync;
      logic sense_ok;
      rt_state_t rt;
      logic [31:0] rt_cnt;
      logic self_rst;
      logic resume;
      logic [15:0] rdata;
      logic denied;
   } state_t;
   state_t st_r, st_nxt;
   logic [10:0] slot_r [MENU_SLOTS];
   logic [10:0] slot_nxt [MENU_SLOTS];
   logic [7:0] status_live;
   logic [26:0] scaled;
   logic wr_ok;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Status bit packing
   assign status_live = drive_flags;
   assign scaled = 27'(rx_value) * 27'(st_r.scale);
   assign wr_ok = (st_r.lock_stored == CODE_OPEN) || (st_r.lock_stored == CODE_FACTORY)
      || st_r.unlocked || (par_idx == IDX_LOCK_CODE);
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      slot_nxt = slot_r;
      st_nxt.tx_v = 1'b0;
      st_nxt.dst_v = 1'b0;
      st_nxt.store = 1'b0;
      st_nxt.self_rst = 1'b0;
      st_nxt.resume = 1'b0;
      st_nxt.denied = 1'b0;
      // Lock code entry through parameter zero
      if ((st_r.lock_stored != CODE_OPEN) && (param_zero == 16'(st_r.lock_stored))) begin
         st_nxt.unlocked = 1'b1;
      end
      // Parameter writes
      if (par_wr && !wr_ok) begin
         st_nxt.denied = 1'b1;
      end else if (par_wr) begin
         for (int i = 0; i < MENU_SLOTS; i++) begin
            if (par_idx == IDX_MENU_SLOT0 + 11'(i)) begin
               slot_nxt[i] = (par_wdata[10:0] > PARAM_MAX) ? PARAM_MAX : par_wdata[10:0];
            end
         end
         case (par_idx)
            IDX_NODE_ADDR: st_nxt.node_addr = (par_wdata > 16'(ADDR_MAX)) ? ADDR_MAX
               : par_wdata[6:0];
            IDX_RATE_SEL: st_nxt.rate_sel = par_wdata[0];
            // Only modes 1 to 4 accepted
            IDX_MODE_SEL: begin
               if (par_wdata >= 16'(MODE_ASCII) && par_wdata <= 16'(MODE_WIDE)) begin
                  st_nxt.mode = par_wdata[2:0];
               end
            end
            IDX_RSVD: st_nxt.rsvd = par_wdata[7:0];
            IDX_LOCK_CODE: st_nxt.lock_code = par_wdata[7:0];
            IDX_BOOT_DISP: st_nxt.boot_disp = (par_wdata[10:0] > PARAM_MAX) ? PARAM_MAX
               : par_wdata[10:0];
            IDX_XFER_SEL: st_nxt.xfer_sel = (par_wdata[10:0] > PARAM_MAX) ? PARAM_MAX
               : par_wdata[10:0];
            IDX_SCALE: st_nxt.scale = (par_wdata[10:0] > PARAM_MAX) ? PARAM_MAX
               : par_wdata[10:0];
            IDX_STATUS: begin
               if (st_r.led_ovr) begin
                  st_nxt.status_w = par_wdata[7:0];
               end
            end
            IDX_LED_OVR: st_nxt.led_ovr = par_wdata[0];
            IDX_HV_BOARD: st_nxt.hv = par_wdata[0];
            IDX_RIDE_EN: st_nxt.ride_en = par_wdata[0];
            default: st_nxt.denied = 1'b0;
         endcase
      end
      // Read mux
      st_nxt.rdata = 16'h0000;
      for (int i = 0; i < MENU_SLOTS; i++) begin
         if (par_idx == IDX_MENU_SLOT0 + 11'(i)) begin
            st_nxt.rdata = 16'(slot_r[i]);
         end
      end
      case (par_idx)
         IDX_NODE_ADDR: st_nxt.rdata = 16'(st_r.node_addr);
         IDX_RATE_SEL: st_nxt.rdata = 16'(st_r.rate_sel);
         IDX_MODE_SEL: st_nxt.rdata = 16'(st_r.mode);
         IDX_RSVD: st_nxt.rdata = 16'(st_r.rsvd);
         IDX_MAIN_REV: st_nxt.rdata = 16'(MAIN_REV_ID);
         IDX_OPT_REV: st_nxt.rdata = 16'(OPT_REV_ID);
         IDX_LOCK_CODE: st_nxt.rdata = 16'(st_r.lock_code);
         IDX_BOOT_DISP: st_nxt.rdata = 16'(st_r.boot_disp);
         IDX_XFER_SEL: st_nxt.rdata = 16'(st_r.xfer_sel);
         IDX_SCALE: st_nxt.rdata = 16'(st_r.scale);
         IDX_STATUS: st_nxt.rdata = 16'(st_r.led_ovr ? st_r.status_w : status_live);
         IDX_LED_OVR: st_nxt.rdata = 16'(st_r.led_ovr);
         IDX_HV_BOARD: st_nxt.rdata = 16'(st_r.hv);
         IDX_RIDE_EN: st_nxt.rdata = 16'(st_r.ride_en);
         default: st_nxt.rdata = st_nxt.rdata;
      endcase
      // Store on reset with zero at one
      if (drive_reset_cmd && param_zero == STORE_CMD) begin
         st_nxt.store = 1'b1;
         st_nxt.lock_stored = st_r.lock_code;
         st_nxt.unlocked = 1'b0;
      end
      // Rate takes effect at drive reset
      if (drive_reset_cmd || st_r.self_rst) begin
         st_nxt.rate_act = st_r.rate_sel;
      end
      // Boot display on power-on and reset
      if (!st_r.boot_done || drive_reset_cmd) begin
         st_nxt.disp = st_r.boot_disp;
      end
      st_nxt.boot_done = 1'b1;
      // Serial data transfer per mode
      case (st_r.mode)
         MODE_VAR_OUT: begin
            if (bit_tick) begin
               st_nxt.tx_v = 1'b1;
               st_nxt.tx_d = src_value;
            end
         end
         MODE_VAR_IN: begin
            if (rx_valid) begin
               st_nxt.dst_v = 1'b1;
               st_nxt.dst_d = 16'(scaled / 27'(SCALE_RST));
            end
         end
         MODE_WIDE: begin
            if (mains_cycle) begin
               st_nxt.tx_v = 1'b1;
               st_nxt.tx_d = wide_out_value;
            end
            if (rx_valid) begin
               st_nxt.wide_in = rx_value;
            end
         end
         default: st_nxt.tx_v = 1'b0;
      endcase
      // Three-stage pin synchroniser
      st_nxt.sense_sync = {st_r.sense_sync[1:0], mains_sense_input};
      if (st_r.sense_sync[2] == st_r.sense_sync[1]) begin
         st_nxt.sense_ok = st_r.sense_sync[2];
      end
      // Ride-through sequencer
      case (st_r.rt)
         RT_RUN: begin
            if (st_r.ride_en && !st_nxt.sense_ok) begin
               st_nxt.rt = RT_DIP;
               st_nxt.rt_cnt = '0;
            end
         end
         RT_DIP: begin
            if (!st_nxt.sense_ok) begin
               st_nxt.rt_cnt = '0;
            end else if (st_r.rt_cnt == 32'(HEALTHY_CYCLES - 1)) begin
               st_nxt.rt = RT_RST;
               st_nxt.rt_cnt = '0;
               st_nxt.self_rst = 1'b1;
            end else begin
               st_nxt.rt_cnt = st_r.rt_cnt + 32'h1;
            end
         end
         RT_RST: begin
            if (!st_nxt.sense_ok) begin
               st_nxt.rt = RT_DIP;
               st_nxt.rt_cnt = '0;
            end else if (st_r.rt_cnt >= 32'(RESTART_CYCLES - HEALTHY_CYCLES - 1)) begin
               st_nxt.rt = RT_RUN;
               st_nxt.resume = run_cmd && enable_cmd;
            end else begin
               st_nxt.rt_cnt = st_r.rt_cnt + 32'h1;
            end
         end
         default: st_nxt.rt = RT_RUN;
      endcase
   end
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.node_addr <= ADDR_RST;
         st_r.mode <= MODE_ASCII;
         st_r.scale <= SCALE_RST;
         st_r.sense_ok <= 1'b1;
         st_r.sense_sync <= 3'h7;
         st_r.rt <= RT_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end
   generate
      for (genvar g = 0; g < MENU_SLOTS; g++) begin : g_slot
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               slot_r[g] <= 11'h000;
            end else begin
               slot_r[g] <= slot_nxt[g];
            end
         end
         assign menu_slot_idx[g] = slot_r[g];
      end
   endgenerate
   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   // Rate bit picks divider
   baud_tick baud_tick_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .fast(st_r.rate_act),
      .tick(bit_tick)
   );
   wide_ascii wide_ascii_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(wide_read_req),
      .value(wide_out_value),
      .digits(wide_digits),
      .done(wide_digits_valid)
   );
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign par_rdata = st_r.rdata;
   assign par_denied = st_r.denied;
   assign store_pulse = st_r.store;
   assign tx_valid = st_r.tx_v;
   assign tx_value = st_r.tx_d;
   assign dst_wr = st_r.dst_v;
   assign dst_idx = st_r.xfer_sel;
   assign dst_value = st_r.dst_d;
   assign wide_in_value = st_r.wide_in;
   assign rate_fast_active = st_r.rate_act;
   assign keypad_leds = st_r.led_ovr ? st_r.status_w[6:0] : status_live[6:0];
   assign display_param = st_r.disp;
   assign hv_board = st_r.hv;
   assign analog2_is_sense = st_r.ride_en;
   assign fire_inhibit = st_r.rt != RT_RUN;
   assign display_blank = st_r.rt == RT_DIP;
   assign self_reset = st_r.self_rst;
   assign run_resume = st_r.resume;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_addr_clamp: assert property (@(posedge sys_clk) disable iff (rst)
      par_wr && wr_ok && par_idx == IDX_NODE_ADDR && par_wdata == 16'h0064
      |=> st_r.node_addr == ADDR_MAX) else $error("address not clamped");
   chk_rate_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !drive_reset_cmd && !st_r.self_rst |=> $stable(st_r.rate_act))
      else $error("rate changed without reset");
   chk_mode_range: assert property (@(posedge sys_clk) disable iff (rst)
      st_r.mode >= MODE_ASCII && st_r.mode <= MODE_WIDE) else $error("mode out of range");
   chk_store_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      drive_reset_cmd && param_zero == STORE_CMD |=> store_pulse)
      else $error("store missed");
   chk_dip_inhibit: assert property (@(posedge sys_clk) disable iff (rst)
      st_r.ride_en && st_r.rt == RT_RUN && !st_nxt.sense_ok |=> fire_inhibit && display_blank)
      else $error("dip not inhibited");
   chk_dip_timer: assert property (@(posedge sys_clk) disable iff (rst)
      st_r.rt == RT_DIP && !st_nxt.sense_ok |=> st_r.rt_cnt == 0)
      else $error("timer not restarted");
   chk_resume_cmd: assert property (@(posedge sys_clk) disable iff (rst)
      run_resume |-> $past(run_cmd) && $past(enable_cmd)) else $error("resume without run");
   chk_led_ovr: assert property (@(posedge sys_clk) disable iff (rst)
      st_r.led_ovr |-> keypad_leds == st_r.status_w[6:0]) else $error("leds not overridden");
endmodule : drive_misc_config

// ---- testbench/serial_peer.sv ----
// Far-side serial peer model
`timescale 1ns/1ps
module serial_peer #(
   parameter int PER = 12
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Bench request
   input wire logic send,
   input wire logic [15:0] send_value,
   // Toward the block
   output logic rx_valid,
   output logic [15:0] rx_value,
   output logic mains_cycle
);
   int cnt_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_valid <= 1'b0;
         rx_value <= 16'h0000;
         cnt_r <= 0;
         mains_cycle <= 1'b0;
      end else begin
         rx_valid <= send;
         // Idle line alternates the last value with its complement
         rx_value <= send ? send_value : ~rx_value;
         cnt_r <= (cnt_r == PER - 1) ? 0 : cnt_r + 1;
         mains_cycle <= (cnt_r == PER - 1);
      end
   end
endmodule : serial_peer

// ---- testbench/drive_misc_config_tb.sv ----
// Testbench for the drive configuration block
`timescale 1ns/1ps
module drive_misc_config_tb
   import drive_misc_pkg::*;
;
   logic sys_clk = 0, rst = 1, par_wr = 0, drive_reset_cmd = 0, send = 0;
   logic [10:0] par_idx = 11'h000;
   logic [15:0] par_wdata = 16'h0000, send_value = 16'h0000, wide_out_value = 16'h3039;
   logic [15:0] param_zero = 16'h0000, src_value = 16'h0000;
   logic [15:0] par_rdata, tx_value, dst_value, wide_in_value, rx_value;
   logic par_denied, store_pulse, rx_valid, tx_valid, dst_wr, wide_digits_valid;
   logic wide_read_req = 0, mains_sense_input = 1, run_cmd = 1, enable_cmd = 1;
   logic rate_fast_active, bit_tick, mains_cycle, display_blank, hv_board;
   logic analog2_is_sense, fire_inhibit, self_reset, run_resume;
   logic [10:0] dst_idx, display_param;
   logic [10:0] slots [MENU_SLOTS];
   logic [39:0] wide_digits;
   logic [7:0] drive_flags = 8'hA5;
   logic [6:0] keypad_leds;
   int mismatches = 0, cmp_count = 0, n;
   always #5 sys_clk = ~sys_clk;
   drive_misc_config #(.HEALTHY_CYCLES(20), .RESTART_CYCLES(50)) drive_misc_config_inst (
      .sys_clk(sys_clk), .rst(rst), .par_wr(par_wr), .par_idx(par_idx),
      .par_wdata(par_wdata), .par_rdata(par_rdata), .par_denied(par_denied),
      .drive_reset_cmd(drive_reset_cmd), .param_zero(param_zero), .store_pulse(store_pulse),
      .rx_valid(rx_valid), .rx_value(rx_value), .src_value(src_value),
      .wide_out_value(wide_out_value), .tx_valid(tx_valid), .tx_value(tx_value),
      .dst_wr(dst_wr), .dst_idx(dst_idx), .dst_value(dst_value),
      .wide_in_value(wide_in_value), .wide_digits(wide_digits),
      .wide_digits_valid(wide_digits_valid), .wide_read_req(wide_read_req),
      .rate_fast_active(rate_fast_active), .bit_tick(bit_tick), .mains_cycle(mains_cycle),
      .drive_flags(drive_flags), .keypad_leds(keypad_leds), .display_param(display_param),
      .display_blank(display_blank), .menu_slot_idx(slots), .hv_board(hv_board),
      .mains_sense_input(mains_sense_input), .run_cmd(run_cmd), .enable_cmd(enable_cmd),
      .analog2_is_sense(analog2_is_sense), .fire_inhibit(fire_inhibit),
      .self_reset(self_reset), .run_resume(run_resume));
   serial_peer serial_peer_inst (.sys_clk(sys_clk), .rst(rst), .send(send),
      .send_value(send_value), .rx_valid(rx_valid), .rx_value(rx_value),
      .mains_cycle(mains_cycle));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task cmp(input logic [39:0] g, input logic [39:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task wr(input logic [10:0] i, input logic [15:0] v);
      @(posedge sys_clk);
      par_wr <= 1'b1;
      par_idx <= i;
      par_wdata <= v;
      @(posedge sys_clk);
      par_wr <= 1'b0;
   endtask : wr
   task rd(input logic [10:0] i, input logic [15:0] e);
      @(posedge sys_clk);
      par_idx <= i;
      repeat (2) @(posedge sys_clk);
      #1 cmp(par_rdata, e);
   endtask : rd
   task guard(input int lim);
      if (n >= lim) begin
         mismatches++;
         tally_and_finish;
      end
   endtask : guard
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      rd(IDX_NODE_ADDR, 16'h0001);
      rd(IDX_MODE_SEL, 16'h0001);
      rd(IDX_SCALE, 16'h03E8);
      wr(IDX_NODE_ADDR, 16'h0064);
      rd(IDX_NODE_ADDR, 16'h0063);
      wr(IDX_MODE_SEL, 16'h0005);
      rd(IDX_MODE_SEL, 16'h0001);
      for (int m = 4; m >= 1; m--) begin
         wr(IDX_MODE_SEL, 16'(m));
         rd(IDX_MODE_SEL, 16'(m));
      end
   endtask : t_regs
   task t_rate;
      wr(IDX_RATE_SEL, 16'h0001);
      repeat (3) @(posedge sys_clk);
      #1 cmp(rate_fast_active, 1'b0);
      @(posedge sys_clk);
      drive_reset_cmd <= 1'b1;
      @(posedge sys_clk);
      drive_reset_cmd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 cmp(rate_fast_active, 1'b1);
   endtask : t_rate
   task t_in(input logic [15:0] sc, input logic [15:0] v, input logic [15:0] e);
      wr(IDX_SCALE, sc);
      @(posedge sys_clk);
      send <= 1'b1;
      send_value <= v;
      @(posedge sys_clk);
      send <= 1'b0;
      for (n = 0; n < 20 && dst_wr !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(20);
      cmp(dst_idx, 11'h12C);
      cmp(dst_value, e);
   endtask : t_in
   task t_wide;
      wr(IDX_MODE_SEL, 16'h0004);
      for (n = 0; n < 40 && tx_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(40);
      cmp(tx_value, 16'h3039);
      @(posedge sys_clk) #1;
      for (n = 1; n < 40 && tx_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(40);
      cmp(n, 32'h0C);
      @(posedge sys_clk);
      send <= 1'b1;
      send_value <= 16'hA5C3;
      @(posedge sys_clk);
      send <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 cmp(wide_in_value, 16'hA5C3);
      @(posedge sys_clk);
      wide_read_req <= 1'b1;
      @(posedge sys_clk);
      wide_read_req <= 1'b0;
      for (n = 0; n < 40 && wide_digits_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(40);
      cmp(wide_digits, 40'h3132333435);
   endtask : t_wide
   task t_out;
      src_value <= 16'h0BEE;
      wr(IDX_MODE_SEL, 16'h0002);
      repeat (2) @(posedge sys_clk);
      #1;
      for (n = 0; n < 11000 && tx_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(11000);
      cmp(tx_value, 16'h0BEE);
      @(posedge sys_clk) #1;
      for (n = 1; n < 11000 && tx_valid !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(11000);
      cmp(n, BIT_HI_CYC);
   endtask : t_out
   task t_led;
      cmp(keypad_leds, 7'h25);
      wr(IDX_STATUS, 16'h005A);
      rd(IDX_STATUS, 16'h00A5);
      wr(IDX_LED_OVR, 16'h0001);
      wr(IDX_STATUS, 16'h005A);
      rd(IDX_STATUS, 16'h005A);
      cmp(keypad_leds, 7'h5A);
   endtask : t_led
   task t_ride;
      wr(IDX_RIDE_EN, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #1 cmp(analog2_is_sense, 1'b1);
      mains_sense_input <= 1'b0;
      for (n = 0; n < 8 && fire_inhibit !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(8);
      cmp(display_blank, 1'b1);
      mains_sense_input <= 1'b1;
      for (n = 0; n < 40 && self_reset !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(40);
      cmp(n >= 32'h14 && n <= 32'h18, 1'b1);
      for (n = 0; n < 70 && run_resume !== 1'b1; n++) @(posedge sys_clk) #1;
      guard(70);
      cmp(run_resume, 1'b1);
      cmp(n, 32'h1E);
   endtask : t_ride
   task t_lock;
      wr(IDX_HV_BOARD, 16'h0001);
      #1 cmp(hv_board, 1'b1);
      wr(IDX_MENU_SLOT0 + 11'h002, 16'h012F);
      #1 cmp(slots[2], 11'h12F);
      wr(IDX_LOCK_CODE, 16'h002A);
      @(posedge sys_clk);
      param_zero <= STORE_CMD;
      drive_reset_cmd <= 1'b1;
      @(posedge sys_clk);
      param_zero <= 16'h0000;
      drive_reset_cmd <= 1'b0;
      #1 cmp(store_pulse, 1'b1);
      wr(IDX_BOOT_DISP, 16'h0123);
      #1 cmp(par_denied, 1'b1);
      rd(IDX_BOOT_DISP, 16'h0000);
      param_zero <= 16'h002A;
      wr(IDX_BOOT_DISP, 16'h0123);
      @(posedge sys_clk);
      drive_reset_cmd <= 1'b1;
      @(posedge sys_clk);
      drive_reset_cmd <= 1'b0;
      #1 cmp(display_param, 11'h123);
   endtask : t_lock
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs;
      t_rate;
      wr(IDX_XFER_SEL, 16'h012C);
      wr(IDX_MODE_SEL, 16'h0003);
      t_in(16'h03E8, 16'h0123, 16'h0123);
      t_in(16'h01F4, 16'h0200, 16'h0100);
      t_wide;
      t_out;
      t_led;
      t_ride;
      t_lock;
      tally_and_finish;
   end
endmodule : drive_misc_config_tb
